// [rtl/wdsr_pkg.sv]
// Package with register map, field layout and types of the watchdog with software reset
package wdsr_pkg;

  // Special function register addresses
  localparam logic [7:0] WDSR_SEQ_ADDR = 8'hA6;
  localparam logic [7:0] WDSR_CSR_ADDR = 8'hA7;

  // Control and status field positions
  localparam int WDSR_PS_MSB = 7;
  localparam int WDSR_PS_LSB = 5;
  localparam int WDSR_IDLE_BIT = 4;
  localparam int WDSR_SOFT_RESET_FLAG_BIT = 2;
  localparam int WDSR_OVF_BIT = 1;
  localparam int WDSR_RUN_BIT = 0;
  localparam logic [7:0] WDSR_CSR_RESET = 8'h00;

  // Sequence bytes
  localparam logic [7:0] WDSR_FEED_FIRST = 8'h1E;
  localparam logic [7:0] WDSR_FEED_SECOND = 8'hE1;
  localparam logic [7:0] WDSR_SOFT_FIRST = 8'h5A;
  localparam logic [7:0] WDSR_SOFT_SECOND = 8'hA5;

  // Counter structure: timer bits plus prescaler bits
  localparam int WDSR_TIMER_BITS = 14;
  localparam int WDSR_PRESC_BITS = 7;
  localparam int WDSR_PS_BITS = 3;

  typedef enum logic [1:0] {
    WDSR_SEQ_IDLE,
    WDSR_SEQ_FEED,
    WDSR_SEQ_SOFT
  } wdsr_seq_t;

  // One special function register bus cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdsr_sfr_req_t;

endpackage

// [rtl/wdsr_top.sv]
// Watchdog timer with software reset sequence detector on the SPECIAL_FUNCTION_REGISTER bus
//
// How it works
// - Writing 5AH then A5H to the sequence port produces a software reset.
// - That software reset works even while the watchdog is not running.
// - A proper software reset sets soft_reset_flag, overflow_flag stays as it was.
// - Any other sequence resets at once and sets both soft_reset_flag and overflow_flag.
// - Control: period select 7:5, idle_freeze 4, bit 3 unused, flags 2:0; reset 00H.
// - Period select 0 gives 16K cycles, 7 gives 2048K cycles.
// - In idle the counter runs if idle_freeze is 0, holds if it is 1.
// - A time-out reset sets overflow_flag.
// - running_flag is read-only, shows whether the counter runs; writes ignored.
// - Any reset stops the watchdog; only 1EH then E1H restarts it.
// - Sequence port at A6H is write-only and reads as zero.
// - Reads may fall between the two bytes; another SPECIAL_FUNCTION_REGISTER write breaks the sequence.
// - 14-bit timer behind a 7-bit prescaler; time-out is 2^(PS+14) cycles.
// - Time-out gives a reset pulse to the CPU; power-down stops the watchdog.
`timescale 1ns/10ps
`default_nettype none

module wdsr_top #(
  parameter int TIMER_BITS = wdsr_pkg::WDSR_TIMER_BITS,
  parameter int PRESC_BITS = wdsr_pkg::WDSR_PRESC_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sys_reset_in,
  input wire logic cpu_idle,
  input wire logic cpu_power_down,
  output logic [7:0] sfr_rdata_q,
  output logic wdt_reset_q,
  output logic running_flag_q
);

  localparam int PSB = wdsr_pkg::WDSR_PS_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wdsr_pkg::wdsr_sfr_req_t req;
  assign req = '{addr: sfr_addr, wdata: sfr_wdata, wr: sfr_wr, rd: sfr_rd};

  wire logic seq_wr;
  wire logic csr_wr;
  wire logic csr_rd;
  wire logic other_wr;
  assign seq_wr = req.wr && (req.addr == wdsr_pkg::WDSR_SEQ_ADDR);
  assign csr_wr = req.wr && (req.addr == wdsr_pkg::WDSR_CSR_ADDR);
  assign csr_rd = req.rd && (req.addr == wdsr_pkg::WDSR_CSR_ADDR);
  assign other_wr = req.wr && !seq_wr;

  // Byte matches shared by all three sequence states
  wire logic is_feed_first;
  wire logic is_feed_second;
  wire logic is_soft_first;
  wire logic is_soft_second;
  assign is_feed_first = req.wdata == wdsr_pkg::WDSR_FEED_FIRST;
  assign is_feed_second = req.wdata == wdsr_pkg::WDSR_FEED_SECOND;
  assign is_soft_first = req.wdata == wdsr_pkg::WDSR_SOFT_FIRST;
  assign is_soft_second = req.wdata == wdsr_pkg::WDSR_SOFT_SECOND;

  // Fields of a control write
  wire logic [PSB-1:0] wr_period;
  wire logic wr_idle_freeze;
  wire logic wr_soft_flag;
  wire logic wr_ovf_flag;
  assign wr_period = req.wdata[wdsr_pkg::WDSR_PS_MSB:wdsr_pkg::WDSR_PS_LSB];
  assign wr_idle_freeze = req.wdata[wdsr_pkg::WDSR_IDLE_BIT];
  assign wr_soft_flag = req.wdata[wdsr_pkg::WDSR_SOFT_RESET_FLAG_BIT];
  assign wr_ovf_flag = req.wdata[wdsr_pkg::WDSR_OVF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequence detector

  wdsr_pkg::wdsr_seq_t seq_q;
  wdsr_pkg::wdsr_seq_t seq_d;
  logic feed_ok;
  logic soft_ok;
  logic seq_bad;

  always_comb
  begin
    seq_d = seq_q;
    feed_ok = 1'b0;
    soft_ok = 1'b0;
    seq_bad = 1'b0;
    if (seq_wr)
    begin
      case (seq_q)
        wdsr_pkg::WDSR_SEQ_IDLE:
        begin
          if (is_feed_first)
            seq_d = wdsr_pkg::WDSR_SEQ_FEED;
          else if (is_soft_first)
            seq_d = wdsr_pkg::WDSR_SEQ_SOFT;
          else
            seq_bad = 1'b1;
        end
        wdsr_pkg::WDSR_SEQ_FEED:
        begin
          seq_d = wdsr_pkg::WDSR_SEQ_IDLE;
          if (is_feed_second)
            feed_ok = 1'b1;
          else
            seq_bad = 1'b1;
        end
        wdsr_pkg::WDSR_SEQ_SOFT:
        begin
          seq_d = wdsr_pkg::WDSR_SEQ_IDLE;
          if (is_soft_second)
            soft_ok = 1'b1;
          else
            seq_bad = 1'b1;
        end
        default:
          seq_d = wdsr_pkg::WDSR_SEQ_IDLE;
      endcase
    end
    else if (other_wr)
    begin
      // Abandon a half sequence; reads leave it alone
      seq_d = wdsr_pkg::WDSR_SEQ_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: prescaler carry feeds the timer

  logic [PRESC_BITS-1:0] presc_q;
  logic [TIMER_BITS-1:0] timer_q;
  logic [PSB-1:0] period_q;
  logic idle_freeze_q;
  logic soft_flag_q;
  logic ovf_flag_q;

  wire logic [TIMER_BITS-1:0] timer_mask;
  wire logic count_en;
  wire logic presc_tick;
  wire logic timeout;
  wire logic own_reset;
  wire logic any_reset;
  wire logic count_clr;

  // Period select n keeps the low n+7 timer bits; the prescaler adds the rest
  assign timer_mask = {TIMER_BITS{1'b1}} >> (PSB'(PRESC_BITS) - period_q);
  assign count_en = running_flag_q && !cpu_power_down
    && !(cpu_idle && idle_freeze_q);
  // Timer moves only on the one-cycle prescaler carry
  assign presc_tick = count_en && (presc_q == '1);
  assign timeout = presc_tick && ((timer_q | ~timer_mask) == '1);
  assign own_reset = timeout || soft_ok || seq_bad;
  assign any_reset = own_reset || sys_reset_in;
  // Stopped or freshly fed: both stages restart from zero
  assign count_clr = feed_ok || any_reset || !running_flag_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_q <= '0;
    else if (count_clr)
      presc_q <= '0;
    else if (count_en)
      presc_q <= presc_q + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_q <= '0;
    else if (count_clr)
      timer_q <= '0;
    else if (presc_tick)
      timer_q <= timer_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running state

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      running_flag_q <= 1'b0;
    else if (any_reset || cpu_power_down)
      running_flag_q <= 1'b0;
    else if (feed_ok)
      running_flag_q <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      seq_q <= wdsr_pkg::WDSR_SEQ_IDLE;
    else if (any_reset)
      seq_q <= wdsr_pkg::WDSR_SEQ_IDLE;
    else
      seq_q <= seq_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status register

  // Settings go back to reset value on a system reset, flags survive it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_q <= wdsr_pkg::WDSR_CSR_RESET[wdsr_pkg::WDSR_PS_MSB:wdsr_pkg::WDSR_PS_LSB];
      idle_freeze_q <= wdsr_pkg::WDSR_CSR_RESET[wdsr_pkg::WDSR_IDLE_BIT];
    end
    else if (any_reset)
    begin
      period_q <= wdsr_pkg::WDSR_CSR_RESET[wdsr_pkg::WDSR_PS_MSB:wdsr_pkg::WDSR_PS_LSB];
      idle_freeze_q <= wdsr_pkg::WDSR_CSR_RESET[wdsr_pkg::WDSR_IDLE_BIT];
    end
    else if (csr_wr)
    begin
      period_q <= wr_period;
      idle_freeze_q <= wr_idle_freeze;
    end
  end

  // Hardware set wins over a software write in the same cycle
  wire logic soft_set;
  wire logic ovf_set;
  assign soft_set = soft_ok || seq_bad;
  assign ovf_set = timeout || seq_bad;

  wdsr_sticky_flag #(
    .RESET_VAL(wdsr_pkg::WDSR_CSR_RESET[wdsr_pkg::WDSR_SOFT_RESET_FLAG_BIT])
  ) u_soft_flag (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hw_set(soft_set),
    .sw_wr(csr_wr),
    .sw_val(wr_soft_flag),
    .flag_q(soft_flag_q)
  );

  wdsr_sticky_flag #(
    .RESET_VAL(wdsr_pkg::WDSR_CSR_RESET[wdsr_pkg::WDSR_OVF_BIT])
  ) u_ovf_flag (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hw_set(ovf_set),
    .sw_wr(csr_wr),
    .sw_val(wr_ovf_flag),
    .flag_q(ovf_flag_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data and reset pulse

  // Each field at its own position; bit 3 reads as zero
  logic [7:0] csr_view;
  always_comb
  begin
    csr_view = '0;
    csr_view[wdsr_pkg::WDSR_PS_MSB:wdsr_pkg::WDSR_PS_LSB] = period_q;
    csr_view[wdsr_pkg::WDSR_IDLE_BIT] = idle_freeze_q;
    csr_view[wdsr_pkg::WDSR_SOFT_RESET_FLAG_BIT] = soft_flag_q;
    csr_view[wdsr_pkg::WDSR_OVF_BIT] = ovf_flag_q;
    csr_view[wdsr_pkg::WDSR_RUN_BIT] = running_flag_q;
  end

  // The sequence port has no storage, so only the control address answers
  wire logic [7:0] sfr_rdata_d;
  assign sfr_rdata_d = csr_rd ? csr_view : '0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata_q <= '0;
    else
      sfr_rdata_q <= sfr_rdata_d;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wdt_reset_q <= 1'b0;
    else
      wdt_reset_q <= own_reset;
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// One status bit that hardware sets and software writes

module wdsr_sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hw_set,
  input wire logic sw_wr,
  input wire logic sw_val,
  output logic flag_q
);

  // Set is tested first, so an event never loses to a clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= RESET_VAL;
    else if (hw_set)
      flag_q <= 1'b1;
    else if (sw_wr)
      flag_q <= sw_val;
  end

endmodule

`default_nettype wire

// [verif/wdsr_props.sv]
// Checker for the watchdog sequence port and control register
`timescale 1ns/10ps
`default_nettype none
module wdsr_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sys_reset_in,
  input wire logic cpu_power_down,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic wdt_reset_q,
  input wire logic running_flag_q
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire w6 = sfr_wr && sfr_addr == 8'hA6;
  wire r7 = sfr_rd && sfr_addr == 8'hA7;
  ////////////////////////////////////////
  // Leading write elsewhere drops any half sequence
  sequence s_two(a, b);
    sfr_wr && !w6 ##1 !sfr_wr ##1 w6 && sfr_wdata == a ##1 !sfr_wr
      ##1 w6 && sfr_wdata == b;
  endsequence
  property p_soft;
    s_two(8'h5A, 8'hA5) |=> wdt_reset_q && !running_flag_q;
  endproperty
  a_soft: assert property (p_soft) else $error("no soft reset");
  property p_feed;
    s_two(8'h1E, 8'hE1) ##0 !cpu_power_down && !sys_reset_in
      |=> running_flag_q && !wdt_reset_q;
  endproperty
  a_feed: assert property (p_feed) else $error("feed did not start");
  property p_bad;
    w6 && !(sfr_wdata inside {8'h1E, 8'hE1, 8'h5A, 8'hA5}) |=> wdt_reset_q;
  endproperty
  a_bad: assert property (p_bad) else $error("bad byte gave no reset");
  property p_pulse;
    wdt_reset_q |=> !wdt_reset_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_stop;
    wdt_reset_q |-> !running_flag_q;
  endproperty
  a_stop: assert property (p_stop) else $error("runs during reset");
  property p_quiet;
    !r7 |=> sfr_rdata_q == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data not zero");
  property p_rd;
    r7 |=> sfr_rdata_q[0] == $past(running_flag_q) && !sfr_rdata_q[3];
  endproperty
  a_rd: assert property (p_rd) else $error("control read wrong");
  property p_drop;
    w6 && sfr_wdata == 8'h1E ##1 !sfr_wr ##1 sfr_wr && !w6 |=> !wdt_reset_q;
  endproperty
  a_drop: assert property (p_drop) else $error("abandon gave reset");
endmodule
bind wdsr_top wdsr_props u_props (.core_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
  .sfr_rd, .sys_reset_in, .cpu_power_down, .sfr_rdata_q, .wdt_reset_q, .running_flag_q);
`default_nettype wire

// [verif/wdsr_top_test.sv]
// Self-checking bench for the watchdog with software reset
`timescale 1ns/10ps
`default_nettype none
module wdsr_top_test;
  logic core_clk = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, sys_reset_in = 1'h0;
  logic cpu_idle = 1'h0, cpu_power_down = 1'h0, wdt_reset_q, running_flag_q;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_q;
  int bad_count = 0, total_checks = 0, cyc = 0, t0;
  wdsr_top dut (.core_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sys_reset_in, .cpu_idle, .cpu_power_down, .sfr_rdata_q, .wdt_reset_q, .running_flag_q);
  initial forever #12.5 core_clk = ~core_clk;
  // Three full time-outs dominate the run
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 75000)
    begin
      bad_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // Returns at the falling edge so one-cycle outputs are still up
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    @(posedge core_clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, r, a, d};
    @(posedge core_clk);
    {sfr_wr, sfr_rd} <= 2'h0;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'h1, 1'h0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    bus(1'h0, 1'h1, a, 8'h00);
    chk("rdata", e, sfr_rdata_q);
  endtask
  task automatic seq(input logic [7:0] c, f, g);
    wr(8'hA7, c);
    wr(8'hA6, f);
    wr(8'hA6, g);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rd(8'hA7, 8'h00);
    rd(8'hA6, 8'h00);
    wr(8'hA7, 8'hF9);
    rd(8'hA7, 8'hF0);
  endtask
  task automatic t_bad;
    wr(8'hA6, 8'h33);
    rd(8'hA7, 8'h06);
    seq(8'h00, 8'h1E, 8'h5A);
    chk("rst", 1, wdt_reset_q);
    rd(8'hA7, 8'h06);
  endtask
  task automatic t_soft;
    seq(8'hE0, 8'h5A, 8'hA5);
    chk("rst", 1, wdt_reset_q);
    rd(8'hA7, 8'h04);
  endtask
  task automatic t_time(input logic [7:0] c, input int hold, input int exp);
    seq(c, 8'h1E, 8'hE1);
    t0 = cyc;
    chk("run", 1, running_flag_q);
    @(posedge core_clk);
    cpu_idle <= 1'h1;
    repeat (hold) @(posedge core_clk);
    cpu_idle <= 1'h0;
    while (!wdt_reset_q) @(negedge core_clk);
    chk("period", exp, cyc - t0);
    rd(8'hA7, 8'h02);
  endtask
  task automatic t_mix;
    seq(8'h00, 8'h1E, 8'hE1);
    wr(8'hA6, 8'h1E);
    rd(8'hA7, 8'h01);
    wr(8'hA6, 8'hE1);
    chk("rst", 0, wdt_reset_q);
    wr(8'hA6, 8'h1E);
    wr(8'hA7, 8'h00);
    chk("run", 1, running_flag_q);
    @(posedge core_clk);
    cpu_power_down <= 1'h1;
    @(posedge core_clk);
    cpu_power_down <= 1'h0;
    @(negedge core_clk);
    chk("run", 0, running_flag_q);
  endtask
  task automatic t_sys;
    seq(8'hF6, 8'h1E, 8'hE1);
    chk("run", 1, running_flag_q);
    @(posedge core_clk);
    sys_reset_in <= 1'h1;
    @(posedge core_clk);
    sys_reset_in <= 1'h0;
    @(negedge core_clk);
    chk("run", 0, running_flag_q);
    rd(8'hA7, 8'h06);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    t_regs();
    t_bad();
    t_soft();
    t_time(8'h10, 1000, 17384);
    t_time(8'h00, 1000, 16384);
    t_time(8'h20, 1000, 32768);
    t_mix();
    t_sys();
    end_sim();
  end
endmodule
`default_nettype wire
